//--- adc_ctrl_pkg.sv
// Constants, types and helpers shared by the converter control block.
// Operation
// - Conversion yields a ten-bit binary result.
// - Twelve or sixteen analog inputs by package.
// - Channel field bits 5:2 selects input n.
// - Small package: channel codes 12-15 select nothing.
// - Status bit 1 reads busy; set starts.
// - Bit 0 enables or disables the converter.
// - Bits 7:6 of both registers read zero.
// - Bits 5:4 choose the reference pair.
// - Low four bits configure analog/digital pins.
// - Third register: clock, acquisition delay, justification.
// - Completion loads result, clears busy, sets flag.
// - Code zero all analog, else 0..14-k analog.
// - Reset clears registers and aborts conversion.
package adc_ctrl_pkg;

    // ------------------------------------------------------------
    // Register addresses.
    // ------------------------------------------------------------
    localparam logic [2:0] CONV_CTRL_ADDR = 3'h0;
    localparam logic [2:0] REF_PIN_ADDR = 3'h1;
    localparam logic [2:0] TIMING_ADDR = 3'h2;
    localparam logic [2:0] RES_HIGH_ADDR = 3'h3;
    localparam logic [2:0] RES_LOW_ADDR = 3'h4;
    localparam logic [2:0] FLAG_ADDR = 3'h5;

    // ------------------------------------------------------------
    // Field positions, masks and reset values.
    // ------------------------------------------------------------
    localparam int EN_BIT = 0;
    localparam int GO_BIT = 1;
    localparam int CHAN_LSB = 2;
    localparam int CHAN_MSB = 5;
    localparam int REF_LSB = 4;
    localparam int REF_MSB = 5;
    localparam int PIN_CFG_MSB = 3;
    localparam int CLK_SEL_MSB = 2;
    localparam int ACQ_LSB = 3;
    localparam int ACQ_MSB = 5;
    localparam int JUSTIFY_BIT = 7;
    localparam int FLAG_BIT = 0;
    localparam logic [7:0] TIMING_MASK = 8'hbf;
    localparam logic [7:0] REG_RESET = 8'h00;

    // ------------------------------------------------------------
    // Converter sizes and timing.
    // ------------------------------------------------------------
    localparam int RESULT_BITS = 10;
    localparam int CHANNELS_MAX = 16;
    localparam logic [3:0] MSB_IDX = 4'h9;
    localparam logic [9:0] SAR_FIRST = 10'h200;
    localparam logic [4:0] SETTLE_TADS = 5'h02;

    // Bus request travelling as one unit.
    typedef struct packed {
        logic [2:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } bus_req_type;

    // Analog front-end steering.
    typedef struct packed {
        logic [3:0] channel;
        logic channel_valid;
        logic [1:0] reference_select;
        logic [15:0] pin_analog;
    } analog_cfg_type;

    // Conversion clock period in system cycles, minus one.
    function automatic logic [6:0] tad_last(input logic [2:0] sel,
                                            input logic [6:0] rc_last);
        unique case (sel)
            3'h0: tad_last = 7'h01;
            3'h1: tad_last = 7'h07;
            3'h2: tad_last = 7'h1f;
            3'h4: tad_last = 7'h03;
            3'h5: tad_last = 7'h0f;
            3'h6: tad_last = 7'h3f;
            default: tad_last = rc_last;
        endcase
    endfunction : tad_last

    // Acquisition delay in conversion clock periods.
    function automatic logic [4:0] acq_tads(input logic [2:0] sel);
        unique case (sel)
            3'h0: acq_tads = 5'h00;
            3'h1: acq_tads = 5'h02;
            3'h2: acq_tads = 5'h04;
            3'h3: acq_tads = 5'h06;
            3'h4: acq_tads = 5'h08;
            3'h5: acq_tads = 5'h0c;
            3'h6: acq_tads = 5'h10;
            default: acq_tads = 5'h14;
        endcase
    endfunction : acq_tads

    // Result placed right or left justified in sixteen bits.
    function automatic logic [15:0] justify(input logic [9:0] r,
                                            input logic right);
        justify = right ? {6'h00, r} : {r, 6'h00};
    endfunction : justify

endpackage : adc_ctrl_pkg

//--- adc_control_registers.sv
// Converter control registers with successive-approximation sequencer.
//
// The plain strobed port and the placing of the registers were decided locally.
`timescale 1ns/100ps
module adc_control_registers
    import adc_ctrl_pkg::*;
#(
    parameter int NUM_INPUTS = 16,
    parameter logic [6:0] RC_TAD_LAST = 7'h3f
) (
    // Clock and reset.
    input wire logic clock_i,
    input wire logic reset_i,
    // Register port.
    input wire bus_req_type bus_i,
    output logic [7:0] rdata_o,
    // Analog front end.
    input wire logic cmp_i,
    output analog_cfg_type cfg_o,
    output logic sample_o,
    output logic [9:0] sar_code_o,
    // Status.
    output logic busy_o,
    output logic conversion_done_flag_o
);

    // ------------------------------------------------------------
    // State.
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        idle_st, acquire_st, convert_st, settle_st
    } conv_state_type;

    conv_state_type state_ff, nxt_state; // Sequencer state.
    logic [3:0] channel_select_ff, nxt_channel_select;
    logic converter_enable_ff, nxt_converter_enable;
    logic [5:0] ref_pin_ff, nxt_ref_pin; // Reference and pins.
    logic [7:0] timing_ff, nxt_timing; // Clock, delay, justify.
    logic [7:0] result_high_ff, nxt_result_high;
    logic [7:0] result_low_ff, nxt_result_low;
    logic flag_ff, nxt_flag; // Conversion done flag.
    logic [7:0] rdata_ff, nxt_rdata;
    logic [6:0] tad_ff, nxt_tad; // Divider toward one period.
    logic [4:0] phase_ff, nxt_phase; // Periods spent in state.
    logic [9:0] sar_ff, nxt_sar; // Trial code.
    logic [3:0] idx_ff, nxt_idx; // Bit under trial.
    logic cmp_meta_ff, cmp_ff; // Comparator synchroniser.
    logic [1:0] age_ff, nxt_age; // Edges since the trial code moved.
    logic cmp_fresh; // Synchronised compare matches the trial.
    logic tick; // Last system cycle of a period.
    logic converting; // Acquiring or converting.
    logic done; // Completion pulse.
    logic [9:0] trial;
    logic [15:0] placed;
    logic [4:0] acq_n;

    // ------------------------------------------------------------
    // Pin map: code zero is all analog, code k keeps 0 to 14-k.
    // ------------------------------------------------------------
    function automatic logic [15:0] pin_map(input logic [3:0] k);
        pin_map = '0;
        for (int i = 0; i < CHANNELS_MAX; i++) begin
            pin_map[i] = ((k == '0)
                || (i < (CHANNELS_MAX - 1) - int'(k)))
                && (i < NUM_INPUTS);
        end
    endfunction : pin_map

    // ------------------------------------------------------------
    // Outputs.
    // ------------------------------------------------------------
    assign tick = (tad_ff == tad_last(timing_ff[CLK_SEL_MSB:0],
                                      RC_TAD_LAST));
    assign converting = (state_ff == acquire_st)
        || (state_ff == convert_st);
    assign cmp_fresh = age_ff[1]; // Two edges have passed.
    assign acq_n = acq_tads(timing_ff[ACQ_MSB:ACQ_LSB]);
    assign rdata_o = rdata_ff;
    assign sample_o = (state_ff == acquire_st);
    assign sar_code_o = sar_ff;
    assign busy_o = converting;
    assign conversion_done_flag_o = flag_ff;
    // The mux follows the stored code; absent inputs are flagged.
    assign cfg_o.channel = channel_select_ff;
    assign cfg_o.channel_valid =
        (int'(channel_select_ff) < NUM_INPUTS);
    assign cfg_o.reference_select =
        ref_pin_ff[REF_MSB:REF_LSB];
    assign cfg_o.pin_analog = pin_map(ref_pin_ff[PIN_CFG_MSB:0]);

    // ------------------------------------------------------------
    // Next-state logic for registers and sequencer.
    // ------------------------------------------------------------
    always_comb begin
        nxt_state = state_ff;
        nxt_channel_select = channel_select_ff;
        nxt_converter_enable = converter_enable_ff;
        nxt_ref_pin = ref_pin_ff;
        nxt_timing = timing_ff;
        nxt_result_high = result_high_ff;
        nxt_result_low = result_low_ff;
        nxt_flag = flag_ff;
        nxt_rdata = '0;
        nxt_tad = tad_ff;
        nxt_phase = phase_ff;
        nxt_sar = sar_ff;
        nxt_idx = idx_ff;
        nxt_age = age_ff;
        done = 1'b0;
        trial = sar_ff;
        placed = '0;
        // Reads: data stand for one cycle only; spare bits are zero.
        if (bus_i.rd) begin
            unique case (bus_i.addr)
                CONV_CTRL_ADDR: begin
                    nxt_rdata[CHAN_MSB:CHAN_LSB] = channel_select_ff;
                    nxt_rdata[GO_BIT] = converter_enable_ff
                        && converting;
                    nxt_rdata[EN_BIT] = converter_enable_ff;
                end
                REF_PIN_ADDR: nxt_rdata[REF_MSB:0] = ref_pin_ff;
                TIMING_ADDR: nxt_rdata = timing_ff;
                RES_HIGH_ADDR: nxt_rdata = result_high_ff;
                RES_LOW_ADDR: nxt_rdata = result_low_ff;
                FLAG_ADDR: nxt_rdata[FLAG_BIT] = flag_ff;
                default: nxt_rdata = '0; // Unmapped reads zero.
            endcase
        end
        // The divider runs whenever the sequencer is not idle, settle included.
        if (state_ff != idle_st) begin
            nxt_tad = tick ? '0 : tad_ff + 7'h01;
        end
        unique case (state_ff)
            idle_st: begin
                nxt_tad = '0;
            end
            acquire_st: begin
                if (tick) begin
                    nxt_phase = phase_ff + 5'h01;
                    if (phase_ff == acq_n - 5'h01) begin
                        nxt_state = convert_st;
                        nxt_sar = SAR_FIRST;
                        nxt_idx = MSB_IDX;
                    end
                end
            end
            convert_st: begin
                // One bit is decided per period, MSB first. The
                // comparator reaches us through two flops, so at the
                // fastest clock a period is stretched by one cycle
                // rather than decided on a stale compare.
                if (tick && !cmp_fresh) begin
                    nxt_tad = tad_ff;
                end else if (tick) begin
                    if (!cmp_ff) begin
                        trial[idx_ff] = 1'b0;
                    end
                    if (idx_ff == '0) begin
                        done = 1'b1;
                        placed = justify(trial,
                                         timing_ff[JUSTIFY_BIT]);
                        nxt_result_high = placed[15:8];
                        nxt_result_low = placed[7:0];
                        nxt_state = settle_st;
                        nxt_phase = '0;
                    end else begin
                        trial[idx_ff - 4'h1] = 1'b1;
                        nxt_idx = idx_ff - 4'h1;
                    end
                    nxt_sar = trial;
                end
            end
            settle_st: begin
                // Rest period before the next acquisition may start.
                if (tick) begin
                    nxt_phase = phase_ff + 5'h01;
                    if (phase_ff == SETTLE_TADS - 5'h01) begin
                        nxt_state = idle_st;
                    end
                end
            end
        endcase
        // Writes come last so a software abort beats the sequencer.
        if (bus_i.wr) begin
            unique case (bus_i.addr)
                CONV_CTRL_ADDR: begin
                    nxt_channel_select =
                        bus_i.wdata[CHAN_MSB:CHAN_LSB];
                    nxt_converter_enable =
                        bus_i.wdata[EN_BIT];
                    if (bus_i.wdata[GO_BIT] && bus_i.wdata[EN_BIT]
                        && state_ff == idle_st) begin
                        // Start; no delay means convert at once.
                        nxt_state = (acq_n == '0) ? convert_st
                            : acquire_st;
                        nxt_tad = '0;
                        nxt_phase = '0;
                        nxt_sar = SAR_FIRST;
                        nxt_idx = MSB_IDX;
                    end else if (!bus_i.wdata[GO_BIT] && converting) begin
                        nxt_state = idle_st; // Clearing busy aborts.
                    end
                end
                REF_PIN_ADDR: nxt_ref_pin = bus_i.wdata[REF_MSB:0];
                TIMING_ADDR: nxt_timing =
                    bus_i.wdata & TIMING_MASK;
                FLAG_ADDR: nxt_flag = bus_i.wdata[FLAG_BIT];
                default: nxt_flag = nxt_flag; // Other writes ignored.
            endcase
        end
        // Switching the converter off stops any conversion.
        if (!nxt_converter_enable && converting) begin
            nxt_state = idle_st;
        end
        // A bit may only be decided two edges after the trial code
        // moved, once both synchroniser flops hold the new compare.
        if (nxt_sar != sar_ff) begin
            nxt_age = '0;
        end else if (!cmp_fresh) begin
            nxt_age = age_ff + 2'h1;
        end
        // Hardware set wins over a software clear in the same cycle.
        if (done) begin
            nxt_flag = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Registers; reset aborts work and clears control.
    // ------------------------------------------------------------
    always_ff @(posedge clock_i or posedge reset_i) begin
        if (reset_i) begin
            state_ff <= idle_st;
            channel_select_ff <= REG_RESET[3:0];
            converter_enable_ff <= 1'b0;
            ref_pin_ff <= REG_RESET[5:0];
            timing_ff <= REG_RESET;
            result_high_ff <= REG_RESET;
            result_low_ff <= REG_RESET;
            flag_ff <= 1'b0;
            rdata_ff <= REG_RESET;
            tad_ff <= '0;
            phase_ff <= '0;
            sar_ff <= '0;
            idx_ff <= '0;
            cmp_meta_ff <= 1'b0;
            cmp_ff <= 1'b0;
            age_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            channel_select_ff <= nxt_channel_select;
            converter_enable_ff <= nxt_converter_enable;
            ref_pin_ff <= nxt_ref_pin;
            timing_ff <= nxt_timing;
            result_high_ff <= nxt_result_high;
            result_low_ff <= nxt_result_low;
            flag_ff <= nxt_flag;
            rdata_ff <= nxt_rdata;
            tad_ff <= nxt_tad;
            phase_ff <= nxt_phase;
            sar_ff <= nxt_sar;
            idx_ff <= nxt_idx;
            cmp_meta_ff <= cmp_i; // Comparator is asynchronous.
            cmp_ff <= cmp_meta_ff;
            age_ff <= nxt_age;
        end
    end

    // ------------------------------------------------------------
    // Assertions.
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (reset_i);

    sequence start_s;
        bus_i.wr && bus_i.addr == CONV_CTRL_ADDR
            && bus_i.wdata[GO_BIT] && bus_i.wdata[EN_BIT]
            && state_ff == idle_st;
    endsequence
    sequence busy_s;
        busy_o && sar_code_o == SAR_FIRST;
    endsequence

    go_read_a: assert property (
        bus_i.rd && bus_i.addr == CONV_CTRL_ADDR
        |=> rdata_o[GO_BIT] == $past(busy_o && converter_enable_ff))
        else $error("Busy bit read back wrong.");
    start_busy_a: assert property (start_s |=> busy_s)
        else $error("Start did not begin a conversion.");
    spare_zero_a: assert property (
        $past(bus_i.rd) && $past(bus_i.addr) <= REF_PIN_ADDR
        |-> rdata_o[7:6] == 2'h0)
        else $error("Spare bits read nonzero.");
    done_flag_a: assert property (
        done |=> flag_ff && !busy_o
            && {result_high_ff, result_low_ff}
               == justify($past(trial), $past(timing_ff[JUSTIFY_BIT])))
        else $error("Completion effects missing.");
    sar_fresh_a: assert property (
        state_ff == convert_st && nxt_sar != sar_ff |-> cmp_fresh)
        else $error("Bit decided on a stale compare.");
    off_idle_a: assert property (
        !converter_enable_ff |-> !busy_o)
        else $error("Converter busy while disabled.");
    channel_map_a: assert property (
        cfg_o.channel_valid == (int'(cfg_o.channel) < NUM_INPUTS))
        else $error("Channel validity wrong.");
    pin_digital_a: assert property (
        ref_pin_ff[PIN_CFG_MSB:0] == 4'hf |-> cfg_o.pin_analog == '0)
        else $error("Pins not all digital.");
    ref_follow_a: assert property (
        bus_i.wr && bus_i.addr == REF_PIN_ADDR
        |=> cfg_o.reference_select == $past(bus_i.wdata[REF_MSB:REF_LSB]))
        else $error("Reference select not updated.");
    reset_clear_a: assert property (
        $past(reset_i) |-> !busy_o && !converter_enable_ff
            && channel_select_ff == '0 && ref_pin_ff == '0)
        else $error("Control not cleared by reset.");

endmodule : adc_control_registers

//--- adc_control_registers_tb.sv
// Self-checking testbench for the converter control register block.
`timescale 1ns/100ps
module adc_control_registers_tb;
    import adc_ctrl_pkg::*;

`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin err_total++; \
$display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end

    // ------------------------------------------------------------
    // Signals and instances.
    // ------------------------------------------------------------
    logic clock_i = 1'b0; // System clock, 40 MHz.
    logic reset_i = 1'b1; // Asynchronous reset, active high.
    bus_req_type bus_i = '0; // Register port request.
    logic [7:0] rdata_o;
    analog_cfg_type cfg_o;
    analog_cfg_type cfg_small; // Front-end steering of the small part.
    logic sample_o;
    logic [9:0] sar_code_o;
    logic busy_o;
    logic conversion_done_flag_o;
    logic [9:0] vin = 10'h000; // Analog level applied to the comparator.
    logic cmp_i;
    int err_total = 0;
    int n_checks = 0;
    logic [7:0] d;
    logic [15:0] res;

    // The comparator is analog and asynchronous, so it follows the trial
    // code at once; the block itself must synchronise it.
    assign cmp_i = (vin >= sar_code_o);

    // The clock toggles every half period.
    always #12.5 clock_i = ~clock_i;

    adc_control_registers DUT (.clock_i(clock_i), .reset_i(reset_i),
        .bus_i(bus_i), .rdata_o(rdata_o), .cmp_i(cmp_i), .cfg_o(cfg_o),
        .sample_o(sample_o), .sar_code_o(sar_code_o), .busy_o(busy_o),
        .conversion_done_flag_o(conversion_done_flag_o));

    // A second copy sized for the small package shares the bus, so only
    // its channel decode is looked at.
    adc_control_registers #(.NUM_INPUTS(12)) dut_small (
        .clock_i(clock_i), .reset_i(reset_i), .bus_i(bus_i), .rdata_o(),
        .cmp_i(cmp_i), .cfg_o(cfg_small), .sample_o(), .sar_code_o(),
        .busy_o(), .conversion_done_flag_o());

    // ------------------------------------------------------------
    // Bus tasks.
    // ------------------------------------------------------------
    // One-cycle write; an idle cycle follows so no strobe is driven twice.
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        bus_i <= '{a, v, 1'b1, 1'b0};
        @(posedge clock_i);
        bus_i <= '0;
        @(posedge clock_i);
    endtask : wr

    // One-cycle read; data are taken in the following cycle only.
    task automatic rd(input logic [2:0] a, output logic [7:0] v);
        bus_i <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clock_i);
        bus_i <= '0;
        @(negedge clock_i);
        v = rdata_o;
        @(negedge clock_i);
        `CHK(rdata_o, 8'h00);
        @(posedge clock_i);
    endtask : rd

    // Waits for busy to drop (sequencer may still settle) under a bounded count.
    task automatic wait_idle(input int lim);
        int i;
        i = 0;
        while (busy_o !== 1'b0 && i < lim) begin
            @(negedge clock_i);
            i++;
        end
        if (i >= lim) begin
            err_total++;
            $display("[ERR] %0t converter stays busy", $time);
            results();
        end
        @(posedge clock_i);
    endtask : wait_idle

    task automatic results();
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    // ------------------------------------------------------------
    // Main sequence.
    // ------------------------------------------------------------
    initial begin
        logic [9:0] vins [5];
        logic [7:0] tmgs [5];
        logic [15:0] pin_exp;
        vins = '{10'h2a5, 10'h3ff, 10'h000, 10'h155, 10'h0aa};
        tmgs = '{8'h81, 8'h19, 8'h81, 8'h80, 8'hac};
        repeat (8) @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);

        // Every register starts cleared, all pins analog.
        for (int a = 0; a < 6; a++) begin
            rd(a[2:0], d);
            `CHK(d, REG_RESET);
        end
        `CHK(cfg_o.pin_analog, 16'hffff);
        $display("test reset_values done");

        // Unimplemented bits, unmapped places and the timing mask.
        wr(CONV_CTRL_ADDR, 8'hfc);
        rd(CONV_CTRL_ADDR, d);
        `CHK(d, 8'h3c);
        wr(REF_PIN_ADDR, 8'hff);
        rd(REF_PIN_ADDR, d);
        `CHK(d, 8'h3f);
        wr(TIMING_ADDR, 8'hff);
        rd(TIMING_ADDR, d);
        `CHK(d, TIMING_MASK);
        wr(3'h6, 8'hff);
        rd(3'h6, d);
        `CHK(d, 8'h00);
        rd(3'h7, d);
        `CHK(d, 8'h00);
        $display("test register_access done");

        // Channel routing on both package sizes.
        for (int c = 0; c < 16; c++) begin
            wr(CONV_CTRL_ADDR, {2'b00, c[3:0], 2'b00});
            `CHK(cfg_o.channel, c[3:0]);
            `CHK(cfg_o.channel_valid, 1'b1);
            `CHK(cfg_small.channel_valid, (c < 12));
        end
        $display("test channel_select done");

        // Pin configuration codes and reference pairs.
        for (int k = 0; k < 16; k++) begin
            wr(REF_PIN_ADDR, {2'b00, k[1:0], k[3:0]});
            pin_exp = (k == 0) ? 16'hffff : (16'hffff >> (k + 1));
            `CHK(cfg_o.pin_analog, pin_exp);
            `CHK(cfg_o.reference_select, k[1:0]);
            rd(REF_PIN_ADDR, d);
            `CHK(d, {2'b00, k[1:0], k[3:0]});
        end
        $display("test pin_reference done");

        // Conversions at boundary levels, both justifications and the
        // fastest and two slower divided conversion clocks.
        for (int i = 0; i < 5; i++) begin
            vin = vins[i];
            wr(TIMING_ADDR, tmgs[i]);
            wr(CONV_CTRL_ADDR, {2'b00, 4'h5 + i[3:0], 2'b11});
            `CHK(busy_o, 1'b1);
            `CHK(sample_o, (tmgs[i][5:3] != 3'h0));
            rd(CONV_CTRL_ADDR, d);
            `CHK(d, {2'b00, 4'h5 + i[3:0], 2'b11});
            wait_idle(400);
            `CHK(conversion_done_flag_o, 1'b1);
            `CHK(sar_code_o, vins[i]);
            rd(CONV_CTRL_ADDR, d);
            `CHK(d, {2'b00, 4'h5 + i[3:0], 2'b01});
            res = tmgs[i][7] ? {6'h00, vins[i]} : {vins[i], 6'h00};
            rd(RES_HIGH_ADDR, d);
            `CHK(d, res[15:8]);
            rd(RES_LOW_ADDR, d);
            `CHK(d, res[7:0]);
            rd(FLAG_ADDR, d);
            `CHK(d, 8'h01);
            wr(FLAG_ADDR, 8'h00);
            `CHK(conversion_done_flag_o, 1'b0);
            // The rest after a result must pass before the next start.
            repeat (24) @(posedge clock_i);
        end
        $display("test conversions done");

        // Disabling mid-conversion aborts with no result.
        vin = 10'h155;
        wr(CONV_CTRL_ADDR, 8'h03);
        repeat (20) @(posedge clock_i);
        wr(CONV_CTRL_ADDR, 8'h00);
        wait_idle(4);
        `CHK(conversion_done_flag_o, 1'b0);
        rd(RES_HIGH_ADDR, d);
        `CHK(d, res[15:8]);
        $display("test abort done");

        // A device reset in mid-conversion clears everything.
        wr(CONV_CTRL_ADDR, 8'h0f);
        repeat (10) @(posedge clock_i);
        reset_i <= 1'b1;
        @(negedge clock_i);
        `CHK(busy_o, 1'b0);
        `CHK(cfg_o.pin_analog, 16'hffff);
        @(posedge clock_i);
        reset_i <= 1'b0;
        @(posedge clock_i);
        rd(CONV_CTRL_ADDR, d);
        `CHK(d, 8'h00);
        rd(TIMING_ADDR, d);
        `CHK(d, 8'h00);
        $display("test mid_reset done");
        results();
    end

endmodule : adc_control_registers_tb
